// [rtl/pwm_out_pkg.sv]
package pwm_out_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPTION = 8'h04;
  localparam logic [7:0] ADDR_MANUAL = 8'h08;
  localparam logic [7:0] ADDR_DEADBAND = 8'h0c;
  localparam logic [7:0] ADDR_DISABLE_MAP_REGISTER = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam int CTRL_GEN_EN = 0;
  localparam int CTRL_MAN_EN = 1;
  localparam int CTRL_DIS_X = 2;
  localparam int CTRL_DIS_Y = 3;
  localparam int CTRL_FSEL_1 = 4;
  localparam int CTRL_FSEL_4 = 5;
  localparam int CTRL_FIE_1 = 6;
  localparam int CTRL_FIE_4 = 7;
  localparam int OPT_SEPARATE = 0;
  localparam int OPT_TOP_INV = 1;
  localparam int OPT_BOT_INV = 2;
  localparam int ST_PIN = 0;
  localparam int ST_FLAG = 2;
  localparam int ST_SOFT = 4;
  localparam int ST_OUT = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] OPTION_RESET = 3'h0;
  localparam logic [7:0] DEADBAND_RESET = 8'hff;
  localparam logic [7:0] DISABLE_MAP_REGISTER_RESET = 8'hff;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/motor_pwm_output_stage.sv]
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module motor_pwm_output_stage
  import pwm_out_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [5:0] gen_compare,
  input wire logic cycle_start,
  input wire logic fault_pin_1,
  input wire logic fault_pin_4,
  output logic [5:0] pwm_pin,
  output logic [5:0] pwm_pin_oe,
  output logic fault_irq_1,
  output logic fault_irq_4,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ------------------------------------------------
  // Helpers
  // ------------------------------------------------
  function automatic logic pin_level(input logic active, input logic invert);
    pin_level = active ^ invert;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == ADDR_CTRL) || (a == ADDR_OPTION) || (a == ADDR_MANUAL) ||
                 (a == ADDR_DEADBAND) || (a == ADDR_DISABLE_MAP_REGISTER) || (a == ADDR_STATUS);
  endfunction

  // ------------------------------------------------
  // Register bus
  // ------------------------------------------------
  logic [7:0] ctrl_r;
  logic [2:0] option_r;
  logic option_done_r;
  logic [5:0] manual_output_register;
  logic [7:0] deadband_count_register;
  logic deadband_done_r;
  logic [7:0] disable_map_register;
  logic disable_map_register_done_r;
  logic [1:0] fault_flag_r;
  logic [1:0] fault_filt_r;
  logic [1:0] soft_dis_r;
  logic [7:0] aw_addr_r;
  logic aw_held_r;
  logic aw_hi_ok_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic w_held_r;
  logic wr_go;
  logic [1:0] ack_nxt;

  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_addr_r <= 8'h00;
      aw_hi_ok_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr[7:0];
        aw_hi_ok_r <= (s_axi_awaddr[31:8] == 24'h0);
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (addr_known(aw_addr_r) && aw_hi_ok_r) ?
                       RESP_OKAY : RESP_SLVERR;
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Control and write-once registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= CTRL_RESET;
      option_r <= OPTION_RESET;
      option_done_r <= 1'b0;
      manual_output_register <= 6'h00;
      deadband_count_register <= DEADBAND_RESET;
      deadband_done_r <= 1'b0;
      disable_map_register <= DISABLE_MAP_REGISTER_RESET;
      disable_map_register_done_r <= 1'b0;
    end else if (ce && wr_go && w_strb_r[0]) begin
      case (aw_addr_r)
        ADDR_CTRL: ctrl_r <= w_data_r[7:0];
        ADDR_OPTION: begin
          if (!option_done_r) begin
            option_r <= w_data_r[2:0];
            option_done_r <= 1'b1;
          end
        end
        ADDR_MANUAL: manual_output_register <= w_data_r[5:0];
        ADDR_DEADBAND: begin
          if (!deadband_done_r) begin
            deadband_count_register <= w_data_r[7:0];
            deadband_done_r <= 1'b1;
          end
        end
        ADDR_DISABLE_MAP_REGISTER: begin
          if (!disable_map_register_done_r) begin
            disable_map_register <= w_data_r[7:0];
            disable_map_register_done_r <= 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  // Fault flag acknowledge: write one to a flag bit in status
  always_comb begin
    ack_nxt = 2'b00;
    if (wr_go && w_strb_r[0] && aw_addr_r == ADDR_STATUS) begin
      ack_nxt = w_data_r[ST_FLAG+1:ST_FLAG];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr[7:0])
          ADDR_CTRL: s_axi_rdata[7:0] <= ctrl_r;
          ADDR_OPTION: s_axi_rdata[2:0] <= option_r;
          ADDR_MANUAL: s_axi_rdata[5:0] <= manual_output_register;
          ADDR_DEADBAND: s_axi_rdata[7:0] <= deadband_count_register;
          ADDR_DISABLE_MAP_REGISTER: s_axi_rdata[7:0] <= disable_map_register;
          ADDR_STATUS: begin
            s_axi_rdata[ST_PIN+1:ST_PIN] <= fault_filt_r;
            s_axi_rdata[ST_FLAG+1:ST_FLAG] <= fault_flag_r;
            s_axi_rdata[ST_SOFT+1:ST_SOFT] <= soft_dis_r;
            s_axi_rdata[ST_OUT+5:ST_OUT] <= pwm_pin;
          end
          default: s_axi_rresp <= RESP_SLVERR;
        endcase
        if (s_axi_araddr[31:8] != 24'h0) begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ------------------------------------------------
  // Fault inputs
  // ------------------------------------------------
  logic [1:0] fin;
  logic [1:0] fin_d1_r;
  logic [1:0] fin_d2_r;
  logic [1:0] fault_hold_r;
  logic [1:0] fsel;
  logic [1:0] fie;
  logic release_tick;
  logic src_manual_r;

  assign fin = {fault_pin_4, fault_pin_1};
  assign fsel = {ctrl_r[CTRL_FSEL_4], ctrl_r[CTRL_FSEL_1]};
  assign fie = {ctrl_r[CTRL_FIE_4], ctrl_r[CTRL_FIE_1]};
  // Without periodic cycles, manual output releases every clock
  assign release_tick = cycle_start || src_manual_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fin_d1_r <= 2'b00;
      fin_d2_r <= 2'b00;
      fault_filt_r <= 2'b00;
      fault_flag_r <= 2'b00;
    end else if (ce) begin
      fin_d1_r <= fin;
      fin_d2_r <= fin_d1_r;
      for (int i = 0; i < 2; i++) begin
        if (!fin[i]) begin
          fault_filt_r[i] <= 1'b0;
        end else if (fin_d1_r[i] && !fin_d2_r[i]) begin
          fault_filt_r[i] <= 1'b1;
        end
        if (fin[i] && fin_d1_r[i] && !fin_d2_r[i] && !fault_filt_r[i]) begin
          fault_flag_r[i] <= 1'b1;
        end else if (ack_nxt[i]) begin
          fault_flag_r[i] <= 1'b0;
        end
      end
    end
  end

  // Disabling latch per fault pin; index 1 is pin 4
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_hold_r <= 2'b00;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        // Latch on the filtered rise; manual pin 1 may clear while still high
        if (fin[i] && fin_d1_r[i] && !fin_d2_r[i]) begin
          fault_hold_r[i] <= 1'b1;
        end else if (release_tick) begin
          if (fsel[i]) begin
            if (!fault_filt_r[i]) begin
              fault_hold_r[i] <= 1'b0;
            end
          end else if (!fault_flag_r[i] && (i == 0 || !fin[i])) begin
            fault_hold_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fault_irq_1 <= 1'b0;
      fault_irq_4 <= 1'b0;
    end else if (ce) begin
      fault_irq_1 <= fault_flag_r[0] && fie[0];
      fault_irq_4 <= fault_flag_r[1] && fie[1];
    end
  end

  // Soft disables, no flag and no request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      soft_dis_r <= 2'b00;
    end else if (ce) begin
      for (int i = 0; i < 2; i++) begin
        if (ctrl_r[CTRL_DIS_X+i]) begin
          soft_dis_r[i] <= 1'b1;
        end else if (release_tick) begin
          soft_dis_r[i] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------
  // Disable mapping
  // ------------------------------------------------
  logic bank_x;
  logic bank_y;
  logic [5:0] chan_off;

  assign bank_x = fault_hold_r[0] || soft_dis_r[0];
  assign bank_y = fault_hold_r[1] || soft_dis_r[1];

  always_comb begin
    chan_off = 6'h00;
    for (int i = 0; i < 4; i++) begin
      if (bank_x && disable_map_register[i]) begin
        chan_off[i] = 1'b1;
      end
      if (bank_y && disable_map_register[4+i]) begin
        chan_off[2+i] = 1'b1;
      end
    end
    if (&disable_map_register && (bank_x || bank_y)) begin
      chan_off = 6'h3f;
    end
  end

  // ------------------------------------------------
  // Source select and dead-time
  // ------------------------------------------------
  logic manual_en;
  logic separate;
  logic [5:0] src;
  logic [2:0] top_in;
  logic [2:0] top_prev_r;
  logic [7:0] dead_cnt_r [3];
  logic [5:0] active;

  assign manual_en = ctrl_r[CTRL_MAN_EN];
  assign separate = option_r[OPT_SEPARATE];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      src_manual_r <= 1'b0;
    end else if (ce) begin
      if (manual_en) begin
        src_manual_r <= 1'b1;
      end else if (cycle_start) begin
        src_manual_r <= 1'b0;
      end
    end
  end

  // Generator outputs count only while the generator is enabled
  assign src = src_manual_r ? manual_output_register :
               (ctrl_r[CTRL_GEN_EN] ? gen_compare : 6'h00);

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      top_in[p] = src[2*p];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      top_prev_r <= 3'h0;
      for (int p = 0; p < 3; p++) begin
        dead_cnt_r[p] <= 8'h00;
      end
    end else if (ce) begin
      top_prev_r <= top_in;
      for (int p = 0; p < 3; p++) begin
        if (top_in[p] != top_prev_r[p]) begin
          dead_cnt_r[p] <= deadband_count_register;
        end else if (dead_cnt_r[p] != 8'h00) begin
          dead_cnt_r[p] <= dead_cnt_r[p] - 8'h01;
        end
      end
    end
  end

  always_comb begin
    for (int p = 0; p < 3; p++) begin
      if (separate) begin
        active[2*p] = src[2*p];
        active[2*p+1] = src[2*p+1];
      end else begin
        // Dead count covers the cycle of the edge and the countdown
        if ((top_in[p] != top_prev_r[p] && deadband_count_register != 8'h00) ||
            dead_cnt_r[p] > 8'h01) begin
          active[2*p] = 1'b0;
          active[2*p+1] = 1'b0;
        end else begin
          active[2*p] = top_in[p];
          active[2*p+1] = !top_in[p] && (!src_manual_r || src[2*p+1]);
        end
      end
    end
  end

  // ------------------------------------------------
  // Pins
  // ------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pwm_pin <= 6'h00;
      pwm_pin_oe <= 6'h00;
    end else if (ce) begin
      for (int c = 0; c < 6; c++) begin
        pwm_pin[c] <= pin_level(active[c] && !chan_off[c],
                                option_r[(c % 2 == 0) ? OPT_TOP_INV : OPT_BOT_INV]);
      end
      pwm_pin_oe <= (ctrl_r[CTRL_GEN_EN] || manual_en || src_manual_r) ? 6'h3f : 6'h00;
    end
  end

endmodule

// [bench/pwm_stage_chk_sva.sv]
`timescale 1ns/1ps
module pwm_stage_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic fault_pin_1,
  input wire logic fault_pin_4,
  input wire logic fault_irq_1,
  input wire logic fault_irq_4,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // ------
  // Steps
  // ------
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_irq1_filter;
    $rose(fault_irq_1) && !$past(s_axi_bvalid) |->
      $past(fault_pin_1, 2) && $past(fault_pin_1, 3) && !$past(fault_pin_1, 4);
  endproperty
  property p_irq4_filter;
    $rose(fault_irq_4) && !$past(s_axi_bvalid) |->
      $past(fault_pin_4, 2) && $past(fault_pin_4, 3) && !$past(fault_pin_4, 4);
  endproperty
  property p_wr_answer;
    s_wr_taken |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endproperty
  property p_rd_answer;
    s_rd_taken |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  property p_wr_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_rd_refused;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_b_release;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  property p_r_release;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_irq1_filter: assert property (p_irq1_filter)
    else $error("fault 1 request without filtered rise");
  a_irq4_filter: assert property (p_irq4_filter)
    else $error("fault 4 request without filtered rise");
  a_wr_answer: assert property (p_wr_answer)
    else $error("write response late");
  a_rd_answer: assert property (p_rd_answer)
    else $error("read data late");
  a_wr_refused: assert property (p_wr_refused)
    else $error("write taken while response pending");
  a_rd_refused: assert property (p_rd_refused)
    else $error("read taken while data pending");
  a_b_release: assert property (p_b_release)
    else $error("write response not released");
  a_r_release: assert property (p_r_release)
    else $error("read data not released");
endmodule
bind motor_pwm_output_stage pwm_stage_chk pwm_stage_chk_i (.*);

// [bench/gate_drive_model.sv]
`timescale 1ns/1ps
module gate_drive_model (
  input wire logic clk,
  input wire logic [5:0] pwm_pin,
  input wire logic [1:0] trip,
  output logic fault_pin_1,
  output logic fault_pin_4,
  output int overlaps
);
  // Top plain, bottom inverted
  initial begin
    fault_pin_1 = 1'h0;
    fault_pin_4 = 1'h0;
    overlaps = 0;
  end
  // Sensors follow trip one clock late; count shoot-through
  always @(posedge clk) begin
    fault_pin_1 <= trip[0];
    fault_pin_4 <= trip[1];
    for (int p = 0; p < 3; p++) begin
      if (pwm_pin[2*p] && !pwm_pin[2*p+1]) begin
        overlaps <= overlaps + 1;
      end
    end
  end
endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import pwm_out_pkg::*;
  logic clk = 1'h0, reset = 1'h1, cycle_start = 1'h0;
  logic [5:0] gen_compare = 6'h00;
  logic [1:0] trip = 2'h0;
  logic fault_pin_1, fault_pin_4, fault_irq_1, fault_irq_4;
  logic [5:0] pwm_pin, pwm_pin_oe;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] rd;
  int failures = 0, checked = 0, overlaps;
  always #20 clk = ~clk;
  motor_pwm_output_stage motor_pwm_output_stage_i (.ce(1'h1), .s_axi_wstrb(4'hf), .*);
  gate_drive_model gate_drive_model_i (.clk(clk), .pwm_pin(pwm_pin), .trip(trip),
    .fault_pin_1(fault_pin_1), .fault_pin_4(fault_pin_4), .overlaps(overlaps));
  // ------
  // Tasks
  // ------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_edge(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic end_of_test();
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    fork
      begin
        do @(posedge clk); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge clk); while (s_axi_wready !== 1'h1);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge clk); while (s_axi_bvalid !== 1'h1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (s_axi_rvalid !== 1'h1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask
  function automatic logic [5:0] pins(input logic [2:0] top, input logic [2:0] bot);
    for (int p = 0; p < 3; p++) begin
      pins[2*p] = top[p];
      pins[2*p+1] = ~bot[p];
    end
  endfunction
  task automatic check_pins(input logic [5:0] exp);
    check("pins", {26'h0, pwm_pin}, {26'h0, exp});
    check("drive", {26'h0, pwm_pin_oe}, 32'h3f);
  endtask
  // Source change, both inactive during dead-time, then final
  task automatic dt_step(input logic man, input logic [5:0] g, input logic [5:0] mid,
                         input logic [5:0] fin);
    if (man) begin
      axi_write(ADDR_MANUAL, {26'h0, g});
    end else begin
      gen_compare <= g;
    end
    wait_edge(3);
    check_pins(mid);
    wait_edge(12);
    check_pins(fin);
  endtask
  // ------
  // Tests
  // ------
  initial begin
    wait_edge(2);
    reset <= 1'h0;
    axi_read(ADDR_OPTION);
    check("option", rd, 32'h0);
    axi_read(ADDR_DISABLE_MAP_REGISTER);
    check("disable_map_register", rd, 32'hff);
    axi_read(8'h40);
    check("unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_write(8'h40, 32'h1);
    check("wr unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_write(ADDR_DEADBAND, 32'h0a);
    axi_write(ADDR_DEADBAND, 32'h05);
    axi_read(ADDR_DEADBAND);
    check("deadband", rd, 32'h0a);
    axi_write(ADDR_OPTION, 32'h4);
    axi_write(ADDR_OPTION, 32'h2);
    axi_read(ADDR_OPTION);
    check("option", rd, 32'h4);
    axi_write(ADDR_CTRL, 32'h81);
    wait_edge(15);
    check_pins(pins(3'h0, 3'h7));
    dt_step(1'h0, 6'h03, pins(3'h0, 3'h6), pins(3'h1, 3'h6));
    dt_step(1'h0, 6'h00, pins(3'h0, 3'h6), pins(3'h0, 3'h7));
    axi_write(ADDR_CTRL, 32'h82);
    wait_edge(15);
    check_pins(pins(3'h0, 3'h0));
    dt_step(1'h1, 6'h3f, pins(3'h0, 3'h0), pins(3'h7, 3'h0));
    dt_step(1'h1, 6'h2a, pins(3'h0, 3'h0), pins(3'h0, 3'h7));
    axi_write(ADDR_CTRL, 32'h86);
    wait_edge(2);
    check_pins(pins(3'h0, 3'h0));
    axi_write(ADDR_CTRL, 32'h82);
    wait_edge(15);
    check_pins(pins(3'h0, 3'h7));
    trip <= 2'h2;
    wait_edge(6);
    check_pins(pins(3'h0, 3'h0));
    check("irq4", {31'h0, fault_irq_4}, 32'h1);
    axi_read(ADDR_STATUS);
    check("status", {28'h0, rd[3:0]}, 32'ha);
    axi_write(ADDR_STATUS, 32'h8);
    wait_edge(5);
    check_pins(pins(3'h0, 3'h0));
    trip <= 2'h0;
    wait_edge(15);
    check_pins(pins(3'h0, 3'h7));
    check("irq4", {31'h0, fault_irq_4}, 32'h0);
    trip <= 2'h1;
    @(posedge clk);
    trip <= 2'h0;
    wait_edge(4);
    axi_read(ADDR_STATUS);
    check("glitch", {28'h0, rd[3:0]}, 32'h0);
    trip <= 2'h1;
    wait_edge(6);
    check_pins(pins(3'h0, 3'h0));
    check("irq1", {31'h0, fault_irq_1}, 32'h0);
    axi_write(ADDR_STATUS, 32'h4);
    wait_edge(15);
    check_pins(pins(3'h0, 3'h7));
    trip <= 2'h0;
    dt_step(1'h1, 6'h00, pins(3'h0, 3'h0), pins(3'h0, 3'h0));
    axi_write(ADDR_CTRL, 32'h81);
    wait_edge(15);
    check_pins(pins(3'h0, 3'h0));
    cycle_start <= 1'h1;
    @(posedge clk);
    cycle_start <= 1'h0;
    wait_edge(15);
    check_pins(pins(3'h0, 3'h7));
    check("overlap", overlaps, 32'h0);
    end_of_test();
  end
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule
